/* File: shared/cpx_pkg.sv */
// Purpose: Shared constants and types for the CPU execute slice.
// Assumes: One clock; operand modes use the 4-bit addressing-mode field.
// Notes:   Cycle and byte figures are minimums before memory wait states.
package cpx_pkg;
   localparam int DW   = 16;             // Data path width
   localparam int BW   = 8;              // Byte width
   localparam int NREG = 6;              // R0..R3, then the two address registers
   localparam int CNT_W = 4;             // Cycle counter width
   localparam int BYT_W = 3;             // Instruction length width

   // Register file indices
   localparam logic [2:0] IDX_A0   = 3'h4;
   localparam logic [2:0] NREG_SEL = 3'h6;

   // Addressing-mode field boundaries
   localparam logic [3:0] MODE_AN_LO    = 4'h4;
   localparam logic [3:0] MODE_MEM_LO   = 4'h6;
   localparam logic [3:0] MODE_DSP8_LO  = 4'h8;
   localparam logic [3:0] MODE_DSP16_LO = 4'hC;

   // Flag register bit positions
   localparam int FLG_C = 0;
   localparam int FLG_D = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_S = 3;
   localparam int FLG_B = 4;
   localparam int FLG_O = 5;
   localparam int FLG_I = 6;
   localparam int FLG_U = 7;

   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [2:0] IPL_RST   = 3'h0;

   // Minimum execution cycles
   localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;
   localparam logic [CNT_W-1:0] CYC_ABS_REG  = 4'h3;
   localparam logic [CNT_W-1:0] CYC_ABS_MEM  = 4'h5;
   localparam logic [CNT_W-1:0] CYC_IMM_REG  = 4'h2;
   localparam logic [CNT_W-1:0] CYC_IMM_MEM  = 4'h4;
   localparam logic [CNT_W-1:0] CYC_RR       = 4'h2;
   localparam logic [CNT_W-1:0] CYC_WAIT     = 4'h1;
   localparam logic [CNT_W-1:0] CYC_UND      = 4'h1;

   // Instruction lengths in bytes
   localparam logic [BYT_W-1:0] BYT_ZERO    = 3'h0;
   localparam logic [BYT_W-1:0] BYT_ABS     = 3'h2;
   localparam logic [BYT_W-1:0] BYT_IMM     = 3'h3;
   localparam logic [BYT_W-1:0] BYT_RR      = 3'h2;
   localparam logic [BYT_W-1:0] BYT_SHORT   = 3'h1;
   localparam logic [BYT_W-1:0] DSP8_BYTES  = 3'h1;
   localparam logic [BYT_W-1:0] DSP16_BYTES = 3'h2;

   typedef enum logic [2:0] {
      OP_TST, OP_UND, OP_WAIT, OP_SWAP, OP_XOR, OP_ABS, OP_ADC
   } cpx_op_t;
endpackage

/* File: shared/cpx_alu_if.sv */
// Purpose: Carries operands and results between sequencer and ALU.
// Assumes: ALU is purely combinational.
// Notes:   Flag results come as a value plus a mask of touched bits.
`timescale 1ns/100ps
interface cpx_alu_if;
   import cpx_pkg::*;
   cpx_op_t         op;                  // Operation
   logic            wide;                // 16-bit operation
   logic [DW-1:0]   src;                 // Source operand
   logic [DW-1:0]   dst;                 // Destination operand
   logic            c_in;                // Carry in
   logic [DW-1:0]   res;                 // Result
   logic [7:0]      fmask;               // Flags touched
   logic [7:0]      fval;                // New flag values
   modport ctl (output op, wide, src, dst, c_in, input res, fmask, fval);
   modport alu (input op, wide, src, dst, c_in, output res, fmask, fval);
endinterface

/* File: rtl/cpx_alu.sv */
// Purpose: Result and flag logic for the execute slice.
// Assumes: Byte operands arrive zero-extended.
// Notes:   No state; the sequencer registers everything.
`timescale 1ns/100ps
module cpx_alu
   import cpx_pkg::*;
(
   cpx_alu_if.alu bus                    // Operand and result bundle
);
   // Result, then flags from the sized result
   always_comb begin
      logic [DW:0]   sum;
      logic [DW-1:0] r;
      logic          neg;
      logic          msb;
      sum = '0;
      msb = 1'h0;
      r   = bus.dst;
      neg = bus.wide ? bus.dst[DW-1] : bus.dst[BW-1];
      bus.fmask = '0;
      bus.fval  = '0;
      case (bus.op)
         OP_TST: begin
            r = bus.src & bus.dst;
            bus.fmask[FLG_S] = 1'h1;
            bus.fmask[FLG_Z] = 1'h1;
         end
         OP_XOR: begin
            r = bus.src ^ bus.dst;
            bus.fmask[FLG_S] = 1'h1;
            bus.fmask[FLG_Z] = 1'h1;
         end
         OP_SWAP: r = bus.src;
         OP_ABS: begin
            r = neg ? DW'(~bus.dst + 1'h1) : bus.dst;
            bus.fmask[FLG_O] = 1'h1;
            bus.fmask[FLG_S] = 1'h1;
            bus.fmask[FLG_Z] = 1'h1;
         end
         OP_ADC: begin
            sum = {1'h0, bus.src} + {1'h0, bus.dst} + {{DW{1'h0}}, bus.c_in};
            r = sum[DW-1:0];
            bus.fmask[FLG_O] = 1'h1;
            bus.fmask[FLG_S] = 1'h1;
            bus.fmask[FLG_Z] = 1'h1;
            bus.fmask[FLG_C] = 1'h1;
         end
         default: r = bus.dst;
      endcase
      // Byte results keep the upper byte clear
      if (!bus.wide) begin
         r = {{BW{1'h0}}, r[BW-1:0]};
      end
      msb = bus.wide ? r[DW-1] : r[BW-1];
      bus.res = r;
      bus.fval[FLG_S] = msb;
      bus.fval[FLG_Z] = (r == '0);
      bus.fval[FLG_C] = bus.wide ? sum[DW] : sum[BW];
      if (bus.op == OP_ABS) begin
         bus.fval[FLG_O] = neg && msb;   // Only the most negative value stays negative
      end else begin
         bus.fval[FLG_O] = bus.wide
            ? (bus.src[DW-1] == bus.dst[DW-1]) && (msb != bus.src[DW-1])
            : (bus.src[BW-1] == bus.dst[BW-1]) && (msb != bus.src[BW-1]);
      end
   end
endmodule

/* File: rtl/cpx_exec.sv */
// Purpose: Execute sequencer for test, trap, wait, swap, xor, abs and adc.
// Assumes: Memory operands are fetched outside and offered with START.
// Notes:   Registers, flags and priority level live here; reached by plain ports.
//
// Notes on behaviour
// - Test ANDs both operands, sets flags, stores nothing.
// - Test sets sign flag from result top bit.
// - Test sets zero flag on zero result; other flags kept.
// - Undefined opcode raises the undefined-instruction interrupt.
// - That interrupt ignores interrupt enable and priority level.
// - Taking it clears stack select, interrupt enable and debug flags.
// - Wait halts execution until resumed; flags unchanged.
// - Halt ends on interrupt above current level, or on reset.
// - Swap exchanges source and destination in one instruction.
// - Byte swap into address register zero-extends; low byte goes back.
// - Xor combines source and destination, result into destination.
// - Byte xor into address register works zero-extended on 16 bits.
// - Byte xor from address register uses its low byte only.
// - Xor sets sign and zero flags; others kept.
// - Cycle counts are minimums; memory wait states stretch them.
// - Abs takes 3 cycles to register, 5 to memory; 2 bytes plus.
// - Immediate adc takes 2 cycles register, 4 memory; 3 bytes base.
// - Word immediate adc is one byte longer.
// - Operand adc takes 2 cycles, plus one per memory operand.
`timescale 1ns/100ps
module cpx_exec
   import cpx_pkg::*;
(
   input  logic            CLK,                    // Core clock, 25 MHz
   input  logic            RST,                    // Sync reset, high
   input  logic            START,                  // Issue instruction
   input  cpx_op_t         OPCODE,                 // Instruction
   input  logic            SIZE_W,                 // Word size when high
   input  logic [3:0]      SRC_MODE,               // Source addressing mode
   input  logic [3:0]      DST_MODE,               // Destination addressing mode
   input  logic            SRC_IMM,                // Source is immediate
   input  logic [DW-1:0]   IMM_DATA,               // Immediate value
   input  logic [DW-1:0]   MEM_SRC_DATA,           // Source memory operand
   input  logic [DW-1:0]   MEM_DST_DATA,           // Destination memory operand
   input  logic            MEM_WAIT,               // Memory wait state
   input  logic            IRQ_REQ,                // Interrupt request
   input  logic [2:0]      IRQ_LEVEL,              // Request priority
   input  logic            REG_WR,                 // Load a register
   input  logic [2:0]      REG_WR_SEL,             // Register to load
   input  logic [DW-1:0]   REG_WR_DATA,            // Load value
   input  logic            FLAG_WR,                // Load flag register
   input  logic [7:0]      FLAG_WR_DATA,           // Flag load value
   input  logic            IPL_WR,                 // Load priority level
   input  logic [2:0]      IPL_WR_DATA,            // Priority load value
   input  logic [2:0]      REG_RD_SEL,             // Register to show
   output logic            BUSY,                   // Instruction executing
   output logic            DONE,                   // Instruction retired
   output logic            HALTED,                 // Core stopped by wait
   output logic            UND_TRAP,               // Undefined-instruction interrupt
   output logic            IRQ_ACK,                // Interrupt woke the core
   output logic            BAD_OPERAND,            // Swap with illegal source
   output logic            MEM_WR,                 // Destination memory write
   output logic [DW-1:0]   MEM_WR_DATA,            // Memory write data
   output logic [BYT_W-1:0] INSN_BYTES,            // Instruction length
   output logic [CNT_W-1:0] INSN_CYCLES,           // Minimum cycle count
   output logic [7:0]      FLAGS,                  // Flag register
   output logic [2:0]      CURRENT_PRIORITY_LEVEL, // Interrupt priority level
   output logic [DW-1:0]   REG_RD_DATA             // Selected register
);

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} cpx_fsm_t;

   typedef struct packed {
      cpx_fsm_t                    fsm;
      logic [CNT_W-1:0]            cnt;
      cpx_op_t                     op;
      logic                        wide;
      logic                        size_w;
      logic [3:0]                  src_mode;
      logic [3:0]                  dst_mode;
      logic [DW-1:0]               srcv;
      logic [DW-1:0]               dstv;
      logic [NREG-1:0][DW-1:0]     regs;
      logic [7:0]                  flags;
      logic [2:0]                  current_priority_level;
      logic                        busy;
      logic                        done;
      logic                        halted;
      logic                        trap;
      logic                        ack;
      logic                        bad;
      logic                        mem_wr;
      logic [DW-1:0]               mem_wr_data;
      logic [BYT_W-1:0]            bytes;
      logic [CNT_W-1:0]            cycles;
      logic [DW-1:0]               rd_data;
   } cpx_state_t;

   cpx_state_t       s;
   cpx_state_t       next_s;
   logic [7:0]       upd_flags;
   logic             dst_an;
   logic             eff_w;
   logic             src_mem;
   logic             dst_mem;
   logic [DW-1:0]    src_val;
   logic [DW-1:0]    dst_val;
   logic [CNT_W-1:0] start_cyc;
   logic [BYT_W-1:0] start_byt;

   cpx_alu_if alu_bus();

   cpx_alu u_alu (
      .bus (alu_bus)
   );

   // Operand read; byte reads of address registers see only the low byte
   function automatic logic [DW-1:0] rd_opnd(
      input logic [3:0]              m,
      input logic                    w,
      input logic [NREG-1:0][DW-1:0] rg,
      input logic [DW-1:0]           md
   );
      logic [DW-1:0] v;
      v = md;
      if (m < MODE_AN_LO) begin
         if (w) begin
            v = rg[m[1:0]];
         end else begin
            v = m[0] ? {{BW{1'h0}}, rg[m[1]][DW-1:BW]} : rg[m[1]];
         end
      end else if (m < MODE_MEM_LO) begin
         v = rg[IDX_A0 + 3'(m[0])];
      end
      if (!w) begin
         v = {{BW{1'h0}}, v[BW-1:0]};
      end
      return v;
   endfunction

   // Register write; address registers always take all 16 bits
   function automatic logic [NREG-1:0][DW-1:0] wr_reg(
      input logic [NREG-1:0][DW-1:0] rg,
      input logic [3:0]              m,
      input logic                    w,
      input logic [DW-1:0]           v
   );
      logic [NREG-1:0][DW-1:0] r;
      r = rg;
      if (m < MODE_AN_LO) begin
         if (w) begin
            r[m[1:0]] = v;
         end else if (m[0]) begin
            r[m[1]][DW-1:BW] = v[BW-1:0];
         end else begin
            r[m[1]][BW-1:0] = v[BW-1:0];
         end
      end else if (m < MODE_MEM_LO) begin
         r[IDX_A0 + 3'(m[0])] = v;
      end
      return r;
   endfunction

   // Extra displacement or address bytes of a mode
   function automatic logic [BYT_W-1:0] dsp_bytes(input logic [3:0] m);
      if (m >= MODE_DSP16_LO) begin
         return DSP16_BYTES;
      end else if (m >= MODE_DSP8_LO) begin
         return DSP8_BYTES;
      end
      return BYT_ZERO;
   endfunction

   // Minimum cycles before any wait state
   function automatic logic [CNT_W-1:0] min_cycles(
      input cpx_op_t op,
      input logic    imm,
      input logic    ms,
      input logic    md
   );
      case (op)
         OP_ABS:  return md ? CYC_ABS_MEM : CYC_ABS_REG;
         OP_WAIT: return CYC_WAIT;
         OP_UND:  return CYC_UND;
         default: begin
            if (imm) begin
               return md ? CYC_IMM_MEM : CYC_IMM_REG;
            end
            return CYC_RR + CNT_W'(ms) + CNT_W'(md);
         end
      endcase
   endfunction

   // Instruction length in bytes
   function automatic logic [BYT_W-1:0] insn_len(
      input cpx_op_t    op,
      input logic       imm,
      input logic       w,
      input logic [3:0] sm,
      input logic [3:0] dm
   );
      case (op)
         OP_ABS:  return BYT_ABS + dsp_bytes(dm);
         OP_WAIT: return BYT_SHORT;
         OP_UND:  return BYT_SHORT;
         OP_SWAP: return BYT_RR + dsp_bytes(dm);
         default: begin
            if (imm) begin
               return BYT_IMM + dsp_bytes(dm) + BYT_W'(w);
            end
            return BYT_RR + dsp_bytes(sm) + dsp_bytes(dm);
         end
      endcase
   endfunction

   // Decode of the instruction on offer
   assign dst_an  = (DST_MODE >= MODE_AN_LO) && (DST_MODE < MODE_MEM_LO);
   assign eff_w   = SIZE_W || dst_an;
   assign src_mem = !SRC_IMM && (SRC_MODE >= MODE_MEM_LO);
   assign dst_mem = DST_MODE >= MODE_MEM_LO;
   assign src_val = SRC_IMM
      ? (SIZE_W ? IMM_DATA : {{BW{1'h0}}, IMM_DATA[BW-1:0]})
      : rd_opnd(SRC_MODE, SIZE_W, s.regs, MEM_SRC_DATA);
   assign dst_val   = rd_opnd(DST_MODE, eff_w, s.regs, MEM_DST_DATA);
   assign start_cyc = min_cycles(OPCODE, SRC_IMM, src_mem, dst_mem);
   assign start_byt = insn_len(OPCODE, SRC_IMM, SIZE_W, SRC_MODE, DST_MODE);

   // ALU sees only latched operands, so no path from ports to results
   assign alu_bus.op   = s.op;
   assign alu_bus.wide = s.wide;
   assign alu_bus.src  = s.srcv;
   assign alu_bus.dst  = s.dstv;
   assign alu_bus.c_in = s.flags[FLG_C];

   // Untouched flags keep their value
   assign upd_flags = (s.flags & ~alu_bus.fmask) | (alu_bus.fval & alu_bus.fmask);

   // Next state
   always_comb begin
      next_s        = s;
      next_s.done   = 1'h0;
      next_s.trap   = 1'h0;
      next_s.ack    = 1'h0;
      next_s.bad    = 1'h0;
      next_s.mem_wr = 1'h0;
      next_s.rd_data = (REG_RD_SEL < NREG_SEL) ? s.regs[REG_RD_SEL] : '0;
      case (s.fsm)
         ST_IDLE: begin
            // Loads only while idle, so a running instruction sees stable state
            if (REG_WR && (REG_WR_SEL < NREG_SEL)) begin
               next_s.regs[REG_WR_SEL] = REG_WR_DATA;
            end
            if (FLAG_WR) begin
               next_s.flags = FLAG_WR_DATA;
            end
            if (IPL_WR) begin
               next_s.current_priority_level = IPL_WR_DATA;
            end
            if (START) begin
               if ((OPCODE == OP_SWAP) && (SRC_IMM || (SRC_MODE >= MODE_AN_LO))) begin
                  next_s.bad = 1'h1;
               end else begin
                  next_s.op       = OPCODE;
                  next_s.size_w   = SIZE_W;
                  next_s.wide     = eff_w;
                  next_s.src_mode = SRC_MODE;
                  next_s.dst_mode = DST_MODE;
                  next_s.srcv     = src_val;
                  next_s.dstv     = dst_val;
                  next_s.cnt      = start_cyc;
                  next_s.cycles   = start_cyc;
                  next_s.bytes    = start_byt;
                  next_s.busy     = 1'h1;
                  next_s.fsm      = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            // A wait state freezes the count, stretching the instruction
            if (!MEM_WAIT) begin
               if (s.cnt > CNT_ONE) begin
                  next_s.cnt = s.cnt - CNT_ONE;
               end else begin
                  next_s.busy = 1'h0;
                  next_s.done = 1'h1;
                  next_s.fsm  = ST_IDLE;
                  case (s.op)
                     OP_TST: begin
                        next_s.flags = upd_flags;
                     end
                     OP_XOR, OP_ADC, OP_ABS: begin
                        next_s.flags = upd_flags;
                        if (s.dst_mode >= MODE_MEM_LO) begin
                           next_s.mem_wr      = 1'h1;
                           next_s.mem_wr_data = alu_bus.res;
                        end else begin
                           next_s.regs = wr_reg(s.regs, s.dst_mode, s.wide, alu_bus.res);
                        end
                     end
                     OP_SWAP: begin
                        // Both halves land together; flags stay as they were
                        if (s.dst_mode >= MODE_MEM_LO) begin
                           next_s.mem_wr      = 1'h1;
                           next_s.mem_wr_data = alu_bus.res;
                           next_s.regs = wr_reg(s.regs, s.src_mode, s.size_w, s.dstv);
                        end else begin
                           next_s.regs = wr_reg(
                              wr_reg(s.regs, s.dst_mode, s.wide, alu_bus.res),
                              s.src_mode, s.size_w, s.dstv);
                        end
                     end
                     OP_UND: begin
                        // Taken with no look at enable or level
                        next_s.trap         = 1'h1;
                        next_s.flags[FLG_U] = 1'h0;
                        next_s.flags[FLG_I] = 1'h0;
                        next_s.flags[FLG_D] = 1'h0;
                     end
                     OP_WAIT: begin
                        next_s.halted = 1'h1;
                        next_s.fsm    = ST_HALT;
                     end
                     default: begin
                        next_s.fsm = ST_IDLE;
                     end
                  endcase
               end
            end
         end
         ST_HALT: begin
            // Only a strictly higher level wakes the core; reset also does
            if (IRQ_REQ && (IRQ_LEVEL > s.current_priority_level)) begin
               next_s.ack    = 1'h1;
               next_s.halted = 1'h0;
               next_s.fsm    = ST_IDLE;
            end
         end
         default: begin
            next_s.fsm = ST_IDLE;
         end
      endcase
   end

   // State register; reset restarts a halted core
   always_ff @(posedge CLK) begin
      if (RST) begin
         s       <= '0;
         s.fsm   <= ST_IDLE;
         s.flags <= FLAGS_RST;
         s.current_priority_level   <= IPL_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign BUSY                   = s.busy;
   assign DONE                   = s.done;
   assign HALTED                 = s.halted;
   assign UND_TRAP               = s.trap;
   assign IRQ_ACK                = s.ack;
   assign BAD_OPERAND            = s.bad;
   assign MEM_WR                 = s.mem_wr;
   assign MEM_WR_DATA            = s.mem_wr_data;
   assign INSN_BYTES             = s.bytes;
   assign INSN_CYCLES            = s.cycles;
   assign FLAGS                  = s.flags;
   assign CURRENT_PRIORITY_LEVEL = s.current_priority_level;
   assign REG_RD_DATA            = s.rd_data;
endmodule

/* File: bench/cpx_exec_assertions.sv */
// Purpose: Port-level checks of the execute slice.
// Assumes: One clock, sync reset high.
// Notes:   Cycle figures are minimums, so the count check is one-sided.
`timescale 1ns/100ps
module cpx_exec_assertions
   import cpx_pkg::*;
(
   input wire logic             CLK,                    // Clock
   input wire logic             RST,                    // Reset
   input wire logic             BUSY,                   // Executing
   input wire logic             DONE,                   // Retired
   input wire logic             HALTED,                 // Waiting
   input wire logic             UND_TRAP,               // Trap
   input wire logic             IRQ_ACK,                // Woken
   input wire logic [2:0]       IRQ_LEVEL,              // Request level
   input wire logic             BAD_OPERAND,            // Refused
   input wire logic [7:0]       FLAGS,                  // Flags
   input wire logic [2:0]       CURRENT_PRIORITY_LEVEL, // Level
   input wire logic [CNT_W-1:0] INSN_CYCLES             // Min cycles
);
   logic [7:0] busy_cnt;
   // Busy cycles of the running instruction
   always_ff @(posedge CLK)
      busy_cnt <= (RST || !BUSY) ? 8'h00 : busy_cnt + 8'h01;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Past values from a reset cycle are excluded where they could mislead
   a_done_ends_busy: assert property ($fell(BUSY) && !$past(RST) |-> DONE)
      else $error("busy ended without done");
   a_count_minimum: assert property (DONE |-> busy_cnt >= 8'(INSN_CYCLES))
      else $error("retired before minimum count");
   a_trap_clears_flags: assert property (UND_TRAP |-> DONE &&
      FLAGS[FLG_U] == 1'b0 && FLAGS[FLG_I] == 1'b0 && FLAGS[FLG_D] == 1'b0)
      else $error("trap left flags set");
   a_halt_on_retire: assert property ($rose(HALTED) |-> DONE)
      else $error("halt without retire");
   a_halt_holds_flags: assert property (HALTED && $past(HALTED) |-> $stable(FLAGS))
      else $error("flags moved while halted");
   a_wake_above_level: assert property (IRQ_ACK |-> $past(HALTED) && !HALTED &&
      $past(IRQ_LEVEL) > $past(CURRENT_PRIORITY_LEVEL))
      else $error("wake without higher level");
   a_refusal_idle: assert property (BAD_OPERAND |-> !BUSY && !DONE)
      else $error("refused swap executed");
   a_never_both: assert property (!(BUSY && HALTED))
      else $error("busy while halted");
   c_trap: cover property (UND_TRAP);
   c_wake: cover property (IRQ_ACK);
   c_refuse: cover property (BAD_OPERAND);
endmodule
bind cpx_exec cpx_exec_assertions chk_u (.*);

/* File: bench/cpx_mem_model.sv */
// Purpose: Far-side data memory and wait-state source.
// Assumes: One cell stands for every destination operand address.
// Notes:   Alternate-cycle stalls give prompt and slow answers.
`timescale 1ns/100ps
module cpx_mem_model
   import cpx_pkg::*;
(
   input  wire logic          clk,     // Clock
   input  wire logic          rst,     // Reset
   input  wire logic          stall,   // Insert wait states
   input  wire logic          wr,      // Write strobe
   input  wire logic [DW-1:0] wr_data, // Write value
   output logic      [DW-1:0] rd_data, // Cell contents
   output logic               wait_st  // Wait state
);
   // Known start value, so no unknown reaches the core
   always_ff @(posedge clk)
      if (rst)
         rd_data <= 16'h1234;
      else if (wr)
         rd_data <= wr_data;
   // Slow on every other cycle while stalling
   always_ff @(posedge clk)
      wait_st <= stall & ~wait_st;
endmodule

/* File: bench/cpx_exec_tb.sv */
// Purpose: Directed run of the execute slice through its plain ports.
// Assumes: Inputs move on the rising edge, outputs are read on the falling one.
// Notes:   Entry nibbles: op, imm*2+word, src mode, dst mode, cycles, bytes.
`timescale 1ns/100ps
module cpx_exec_tb;
   import cpx_pkg::*;
   logic CLK = 1'b0, RST = 1'b1, START = 1'b0, SIZE_W, SRC_IMM, IRQ_REQ = 1'b0, wr_go = 1'b0;
   logic stall = 1'b0, REG_WR, FLAG_WR, IPL_WR, BUSY, DONE, HALTED, UND_TRAP;
   logic IRQ_ACK, BAD_OPERAND, MEM_WR, MEM_WAIT;
   logic [2:0] op_code, IRQ_LEVEL = 3'h0, REG_WR_SEL, REG_RD_SEL, IPL_WR_DATA;
   logic [2:0] CURRENT_PRIORITY_LEVEL;
   logic [3:0] SRC_MODE, DST_MODE, INSN_CYCLES;
   logic [7:0] FLAGS, FLAG_WR_DATA;
   logic [BYT_W-1:0] INSN_BYTES;
   logic [DW-1:0] IMM_DATA, REG_WR_DATA = '0, MEM_DST_DATA, MEM_WR_DATA, REG_RD_DATA;
   logic [23:0] tbl [12] = '{24'h500032, 24'h500432, 24'h500652, 24'h500853, 24'h500C54,
      24'h620023, 24'h630644, 24'h620F45, 24'h600022, 24'h606032, 24'h606642, 24'h608C45};
   int n_mismatch = 0, samples_checked = 0;
   // One load strobe; the select picks register, flags or level
   assign REG_WR = wr_go && REG_WR_SEL < 3'h6;
   assign FLAG_WR = wr_go && REG_WR_SEL == 3'h6;
   assign IPL_WR = wr_go && REG_WR_SEL == 3'h7;
   assign {FLAG_WR_DATA, IPL_WR_DATA} = {REG_WR_DATA[7:0], REG_WR_DATA[2:0]};
   // Source memory operand fixed: only cycle counts depend on it
   cpx_exec dut_u (.*, .OPCODE(cpx_op_t'(op_code)), .MEM_SRC_DATA(16'h5A5A));
   cpx_mem_model mem_u (.clk(CLK), .rst(RST), .stall(stall), .wr(MEM_WR),
      .wr_data(MEM_WR_DATA), .rd_data(MEM_DST_DATA), .wait_st(MEM_WAIT));
   always #20 CLK = ~CLK;
   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ld(input logic [2:0] s, input logic [DW-1:0] v);
      @(posedge CLK);
      {wr_go, REG_WR_SEL, REG_WR_DATA} <= {1'b1, s, v};
      @(posedge CLK);
      wr_go <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [DW-1:0] exp);
      @(posedge CLK);
      REG_RD_SEL <= s;
      repeat (2) @(negedge CLK);
      chk(REG_RD_DATA, exp);
   endtask
   // Issue one entry, wait for retire, compare length and timing
   task automatic go(input logic [23:0] e, input logic [DW-1:0] im);
      int k = 0, w = 0;
      @(posedge CLK);
      {START, op_code, SRC_IMM, SIZE_W, SRC_MODE, DST_MODE} <= {1'b1, e[22:20], e[17:8]};
      IMM_DATA <= im;
      @(posedge CLK);
      START <= 1'b0;
      do begin
         @(negedge CLK);
         k++;
         w += int'(BUSY && MEM_WAIT);
      end while (DONE !== 1'b1 && k < 40);
      chk(INSN_CYCLES, e[7:4]);
      chk(INSN_BYTES, e[2:0]);
      chk(k - w <= e[7:4] + 1 && k >= e[7:4] + 1, 1'b1);
   endtask
   initial begin
      {SIZE_W, SRC_IMM, op_code, SRC_MODE, DST_MODE, REG_WR_SEL, REG_RD_SEL, IMM_DATA} = '0;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      ld(3'h0, 16'hF0F0);
      ld(3'h1, 16'hF00F);
      ld(3'h4, 16'hABCD);
      ld(3'h6, 16'h00FF);
      go(24'h410122, 16'h0000);
      chk(FLAGS, 8'hF3);
      rd(3'h1, 16'h00FF);
      go(24'h030024, 16'h0F0F);
      chk(FLAGS, 8'hF7);
      rd(3'h0, 16'hF0F0);
      go(24'h400422, 16'h0000);
      chk(FLAGS, 8'hFB);
      rd(3'h4, 16'hAB3D);
      go(24'h404222, 16'h0000);
      rd(3'h1, 16'h00C2);
      go(24'h300422, 16'h0000);
      chk(FLAGS, 8'hFB);
      rd(3'h4, 16'h00F0);
      rd(3'h0, 16'hF03D);
      @(posedge CLK) {START, op_code, SRC_MODE} <= {1'b1, 3'h3, 4'h4};
      @(posedge CLK) START <= 1'b0;
      @(negedge CLK);
      chk(BAD_OPERAND, 1'b1);
      $display("test logic ops done");
      @(posedge CLK) stall <= 1'b1;
      go(24'h410632, 16'h0000);
      chk(MEM_WR, 1'b1);
      chk(MEM_WR_DATA, 16'hE209);
      foreach (tbl[i]) go(tbl[i], 16'h0001);
      $display("test cycle table done");
      ld(3'h6, 16'h00FF);
      ld(3'h7, 16'h0007);
      go(24'h100011, 16'h0000);
      chk(UND_TRAP, 1'b1);
      chk(FLAGS, 8'h3D);
      $display("test trap done");
      ld(3'h7, 16'h0003);
      go(24'h200011, 16'h0000);
      chk(HALTED, 1'b1);
      @(posedge CLK) {IRQ_REQ, IRQ_LEVEL} <= 4'hB;
      repeat (3) @(negedge CLK);
      chk(HALTED, 1'b1);
      @(posedge CLK) IRQ_LEVEL <= 3'h4;
      repeat (2) @(negedge CLK);
      chk(IRQ_ACK, 1'b1);
      chk(FLAGS, 8'h3D);
      @(posedge CLK) IRQ_REQ <= 1'b0;
      go(24'h200011, 16'h0000);
      @(posedge CLK) RST <= 1'b1;
      @(posedge CLK) RST <= 1'b0;
      @(negedge CLK);
      chk(HALTED, 1'b0);
      $display("test halt done");
      close_out;
   end
   // Run needs about 200 cycles; this allows over ten times that
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule
